// ==== design/seh_front.sv ====
// Serial EEPROM front end: SPI timing, pause and write protection
// Functional notes
// R1 - Capture serial input on each serial clock rising edge.
// R2 - Drive serial output bits changing on serial clock falling edges.
// R3 - Work in mode 0 and mode 3 clock idle levels.
// R4 - Master selects chip before asserting pause; pause only while selected.
// R5 - Enter pause on pause fall if clock low, else after next clock fall.
// R6 - Leave pause on pause rise if clock low, else after next clock fall.
// R7 - While paused, output high impedance; input and clock ignored.
// R8 - Pause keeps partial instruction and data; transfer resumes where it stopped.
// R9 - Master keeps chip select low during pause; raising it resets state.
// R10 - Power-up leaves write-enable latch cleared.
// R11 - Array and status writes accepted only with write-enable latch set.
// R12 - Write-type command executes only if clock count is multiple of eight.
// R13 - Protect levels: none, 300h-3ffh, 200h-3ffh, all; protected writes refused. Only array writes are checked; sector write (82h) ignores protection.
// R14 - Busy flag at bit 0 reads 1 during write cycles, else 0.
// R15 - While busy, every command except status read is ignored.
// R16 - Write-enable command sets write-enable latch at bit 1.
// R17 - Latch cleared at power-up, write disable and after every write.
// R18 - Protect bits at bits 3 and 2, written by status write, default 0.
// R19 - Lock bit set and guard pin low refuses status writes.
// R20 - Opcode 06h then chip select rising sets write-enable latch.
// R21 - Opcode 04h clears write-enable latch.
// R22 - Opcode 05h streams status MSB first repeatedly, even while busy.
// R23 - Opcode 01h needs exactly one data byte then chip select rising.
// R24 - Lock bit at bit 7; bits 6 to 4 read zero, never written.
// R25 - Chip select high tri-states output and drops partial command bits.
`timescale 1ns/1ps
module seh_front #(
    parameter int unsigned WRITE_CYCLES = seh_pkg::WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic spi_cs_n,
    input wire logic spi_clk,
    input wire logic spi_di,
    input wire logic hold_n,
    input wire logic write_guard_n,
    output logic spi_do,
    output logic spi_do_oe
);

    // ****************************************
    // Parameter check
    // ****************************************
    if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << seh_pkg::TMR_W)) begin : g_bad_cycles
        $error("WRITE_CYCLES out of timer range");
    end

    localparam logic [seh_pkg::TMR_W-1:0] TMR_LOAD = seh_pkg::TMR_W'(WRITE_CYCLES - 1);

    function automatic logic [7:0] status_of(input seh_pkg::seh_state_s s);
        logic [7:0] v;
        v = 8'h00;
        v[seh_pkg::BUSY_POS] = s.busy_flag;
        v[seh_pkg::LATCH_POS] = s.write_enable_latch;
        v[seh_pkg::PROTECT_LO_POS] = s.protect_level[0];
        v[seh_pkg::PROTECT_HI_POS] = s.protect_level[1];
        v[seh_pkg::LOCK_POS] = s.status_lock_bit;
        return v;
    endfunction : status_of

    // ****************************************
    // Pin synchronisation
    // ****************************************
    logic [seh_pkg::SYNC_W-1:0] pins_s;
    logic cs_s;
    logic sclk_s;
    logic di_s;
    logic hold_s;
    logic guard_s;

    seh_sync u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in({spi_cs_n, spi_clk, spi_di, hold_n, write_guard_n}),
        .sync_out(pins_s)
    );

    assign cs_s = pins_s[4];
    assign sclk_s = pins_s[3];
    assign di_s = pins_s[2];
    assign hold_s = pins_s[1];
    assign guard_s = pins_s[0];

    // ****************************************
    // State and events
    // ****************************************
    seh_pkg::seh_state_s st_reg;
    seh_pkg::seh_state_s st_next;
    logic rise;
    logic fall;
    logic cs_rise;
    logic frame_ok;
    logic prot_hit;
    logic [7:0] cur_status;
    logic [7:0] rx_byte;

    // Edges only count while selected and not paused
    assign rise = sclk_s && !st_reg.sclk_d && !cs_s && !st_reg.paused; // R1 R3 R7
    assign fall = !sclk_s && st_reg.sclk_d && !cs_s && !st_reg.paused; // R2 R3 R7
    assign cs_rise = cs_s && !st_reg.cs_d;
    assign frame_ok = (st_reg.cnt[2:0] == 3'h0); // R12
    assign cur_status = status_of(st_reg);
    assign rx_byte = {st_reg.sh[6:0], di_s};

    seh_prot u_prot (
        .level(st_reg.protect_level),
        .addr(st_reg.addr),
        .hit(prot_hit)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.sclk_d = sclk_s;
        st_next.cs_d = cs_s;
        if (cs_s) begin
            // Deselect drops the partial command
            st_next.paused = 1'b0; // R9
            st_next.cnt = '0; // R25
            st_next.op = 8'h00;
            st_next.drop = 1'b0;
            st_next.rd_on = 1'b0; // R25
        end else begin
            // Pause level only follows the pin while the clock is low
            if (!sclk_s) begin
                st_next.paused = !hold_s; // R5 R6
            end
            if (rise) begin
                st_next.sh = {st_reg.sh[14:0], di_s}; // R1
                if (st_reg.cnt != seh_pkg::CNT_MAX) begin
                    st_next.cnt = st_reg.cnt + 16'h0001;
                end
                if (st_reg.cnt == seh_pkg::OPCODE_BITS - 16'h0001) begin
                    st_next.op = rx_byte;
                    st_next.drop = st_reg.busy_flag && (rx_byte != seh_pkg::STATUS_READ_CMD); // R15
                end
                if (st_reg.cnt == seh_pkg::STATUS_WRITE_BITS - 16'h0001 &&
                    st_reg.op == seh_pkg::STATUS_WRITE_CMD && !st_reg.drop) begin
                    st_next.sr_new = rx_byte;
                end
                if (st_reg.cnt == seh_pkg::ADDR_DONE_BITS - 16'h0001) begin
                    st_next.addr = {st_reg.sh[8:0], di_s};
                end
            end
            // Status streams out live, MSB first, wrapping every byte
            if (fall && st_reg.op == seh_pkg::STATUS_READ_CMD && !st_reg.drop &&
                st_reg.cnt >= seh_pkg::OPCODE_BITS) begin
                st_next.dout = cur_status[~st_reg.cnt[2:0]]; // R2 R22
                st_next.rd_on = 1'b1;
            end
        end
        st_next.doe = st_next.rd_on && !st_next.paused; // R7 R8

        // Self-timed cycle
        if (st_reg.busy_flag) begin
            if (st_reg.tmr == '0) begin
                st_next.busy_flag = 1'b0; // R14
                st_next.write_enable_latch = 1'b0; // R17
                if (st_reg.pend_sr) begin
                    st_next.pend_sr = 1'b0;
                    st_next.status_lock_bit = st_reg.sr_new[seh_pkg::LOCK_POS]; // R24
                    st_next.protect_level = {st_reg.sr_new[seh_pkg::PROTECT_HI_POS],
                                             st_reg.sr_new[seh_pkg::PROTECT_LO_POS]}; // R18
                end
            end else begin
                st_next.tmr = st_reg.tmr - 1'b1;
            end
        end

        // Commands execute on deselect
        if (cs_rise && !st_reg.drop && !st_reg.busy_flag && frame_ok) begin // R12 R15
            case (st_reg.op)
                seh_pkg::WRITE_ENABLE_CMD: begin
                    if (st_reg.cnt == seh_pkg::OPCODE_BITS) begin
                        st_next.write_enable_latch = 1'b1; // R16 R20
                    end
                end
                seh_pkg::WRITE_DISABLE_CMD: begin
                    if (st_reg.cnt == seh_pkg::OPCODE_BITS) begin
                        st_next.write_enable_latch = 1'b0; // R21
                    end
                end
                seh_pkg::STATUS_WRITE_CMD: begin
                    if (st_reg.cnt == seh_pkg::STATUS_WRITE_BITS && // R23
                        st_reg.write_enable_latch && // R11
                        !(st_reg.status_lock_bit && !guard_s)) begin // R19
                        st_next.busy_flag = 1'b1; // R14
                        st_next.pend_sr = 1'b1;
                        st_next.tmr = TMR_LOAD;
                    end
                end
                seh_pkg::ARRAY_WRITE_CMD: begin
                    if (st_reg.cnt >= seh_pkg::WRITE_MIN_BITS &&
                        st_reg.write_enable_latch && !prot_hit) begin // R11 R13
                        st_next.busy_flag = 1'b1;
                        st_next.tmr = TMR_LOAD;
                    end
                end
                seh_pkg::SECTOR_WRITE_CMD: begin
                    if (st_reg.cnt >= seh_pkg::WRITE_MIN_BITS && st_reg.write_enable_latch) begin
                        st_next.busy_flag = 1'b1;
                        st_next.tmr = TMR_LOAD;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.sclk_d <= 1'b0;
            st_reg.cs_d <= 1'b1;
            st_reg.write_enable_latch <= seh_pkg::LATCH_RESET; // R10 R17
            st_reg.protect_level <= seh_pkg::PROTECT_RESET; // R18
            st_reg.status_lock_bit <= seh_pkg::LOCK_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign spi_do = st_reg.dout;
    assign spi_do_oe = st_reg.doe;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_deselect_hiz: assert property (cs_s |=> !spi_do_oe) // R25
        else $error("serial output driven while deselected");
    a_pause_hiz: assert property (st_reg.paused |-> !spi_do_oe) // R7
        else $error("serial output driven while paused");
    a_pause_freeze: assert property ((st_reg.paused && !cs_s) |=> // R8
        (st_reg.cnt == $past(st_reg.cnt) && st_reg.sh == $past(st_reg.sh)))
        else $error("pause did not freeze the shift state");
    a_rise_capture: assert property (rise |=> st_reg.sh[0] == $past(di_s)) // R1
        else $error("input bit not captured on clock rise");
    a_status_bit: assert property ((fall && st_reg.op == seh_pkg::STATUS_READ_CMD &&
        !st_reg.drop && st_reg.cnt >= seh_pkg::OPCODE_BITS) |=>
        (spi_do == $past(cur_status[~st_reg.cnt[2:0]]))) // R22
        else $error("wrong status bit shifted out");
    a_latch_set: assert property ((cs_rise && st_reg.op == seh_pkg::WRITE_ENABLE_CMD &&
        st_reg.cnt == seh_pkg::OPCODE_BITS && !st_reg.busy_flag && !st_reg.drop) |=>
        st_reg.write_enable_latch) // R20
        else $error("write enable latch not set");
    a_latch_clear: assert property ((cs_rise && st_reg.op == seh_pkg::WRITE_DISABLE_CMD &&
        st_reg.cnt == seh_pkg::OPCODE_BITS && !st_reg.busy_flag && !st_reg.drop) |=>
        !st_reg.write_enable_latch) // R21
        else $error("write enable latch not cleared");
    a_no_latch_write: assert property ((cs_rise && !st_reg.write_enable_latch &&
        !st_reg.busy_flag) |=> !st_reg.busy_flag) // R11
        else $error("write started without write enable");
    a_odd_frame: assert property ((cs_rise && !frame_ok && !st_reg.busy_flag) |=>
        !st_reg.busy_flag) // R12
        else $error("write started on partial byte frame");
    a_status_locked: assert property ((cs_rise && st_reg.status_lock_bit && !guard_s &&
        st_reg.op == seh_pkg::STATUS_WRITE_CMD && !st_reg.busy_flag) |=>
        !st_reg.busy_flag) // R19
        else $error("status write accepted while locked");
    a_protect_hit: assert property ((cs_rise && prot_hit &&
        st_reg.op == seh_pkg::ARRAY_WRITE_CMD && !st_reg.busy_flag) |=>
        !st_reg.busy_flag) // R13
        else $error("write accepted into protected range");
    a_busy_hold: assert property ((st_reg.busy_flag && st_reg.tmr != '0) |=>
        st_reg.busy_flag ##0 st_reg.tmr == $past(st_reg.tmr) - 1'b1) // R14
        else $error("busy cycle ended early");
    a_busy_end: assert property ($fell(st_reg.busy_flag) |-> !st_reg.write_enable_latch) // R17
        else $error("latch still set after write cycle");
    a_busy_ignore: assert property ((rise && st_reg.busy_flag &&
        st_reg.cnt == seh_pkg::OPCODE_BITS - 16'h0001 &&
        rx_byte != seh_pkg::STATUS_READ_CMD) |=> st_reg.drop) // R15
        else $error("command not ignored while busy");

    c_read_busy: cover property (st_reg.busy_flag && spi_do_oe);
    c_pause: cover property ($rose(st_reg.paused) ##[1:200] $fell(st_reg.paused));
    c_status_write: cover property ($rose(st_reg.pend_sr));
    c_protected: cover property (cs_rise && prot_hit && st_reg.write_enable_latch);

endmodule : seh_front

// ==== design/seh_prot.sv ====
// Block-protect address range decoder
`timescale 1ns/1ps
module seh_prot (
    input wire logic [1:0] level,
    input wire logic [seh_pkg::ADDR_W-1:0] addr,
    output logic hit
);

    always_comb begin
        case (level)
            seh_pkg::PROTECT_NONE: hit = 1'b0;
            seh_pkg::PROTECT_QUARTER: hit = (addr[9:8] == seh_pkg::QUARTER_TOP);
            seh_pkg::PROTECT_HALF: hit = addr[9];
            seh_pkg::PROTECT_ALL: hit = 1'b1;
            default: hit = 1'b1;
        endcase
    end

endmodule : seh_prot

// ==== design/seh_sync.sv ====
// Two-stage synchroniser for the serial pins
`timescale 1ns/1ps
module seh_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [seh_pkg::SYNC_W-1:0] async_in,
    output logic [seh_pkg::SYNC_W-1:0] sync_out
);

    seh_pkg::seh_sync_s st_reg;
    seh_pkg::seh_sync_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.stage1 = async_in;
        st_next.stage2 = st_reg.stage1;
    end

    // Idle levels are constants so reset loads no port value
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '{stage1: seh_pkg::SYNC_IDLE, stage2: seh_pkg::SYNC_IDLE};
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.stage2;

endmodule : seh_sync

// ==== shared/seh_pkg.sv ====
// Constants, commands and state types for the serial EEPROM front end
package seh_pkg;

    // ****************************************
    // Commands
    // ****************************************
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;
    localparam logic [7:0] SECTOR_WRITE_CMD = 8'h82;

    // ****************************************
    // Status register layout and reset values
    // ****************************************
    localparam int BUSY_POS = 0;
    localparam int LATCH_POS = 1;
    localparam int PROTECT_LO_POS = 2;
    localparam int PROTECT_HI_POS = 3;
    localparam int LOCK_POS = 7;
    localparam logic [1:0] PROTECT_RESET = 2'h0;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic LATCH_RESET = 1'b0;

    // ****************************************
    // Protection levels and address ranges
    // ****************************************
    localparam logic [1:0] PROTECT_NONE = 2'h0;
    localparam logic [1:0] PROTECT_QUARTER = 2'h1;
    localparam logic [1:0] PROTECT_HALF = 2'h2;
    localparam logic [1:0] PROTECT_ALL = 2'h3;
    localparam logic [1:0] QUARTER_TOP = 2'h3;
    localparam int ADDR_W = 10;

    // ****************************************
    // Frame bit counts
    // ****************************************
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    localparam logic [CNT_W-1:0] OPCODE_BITS = 16'h0008;
    localparam logic [CNT_W-1:0] STATUS_WRITE_BITS = 16'h0010;
    localparam logic [CNT_W-1:0] ADDR_DONE_BITS = 16'h0018;
    localparam logic [CNT_W-1:0] WRITE_MIN_BITS = 16'h0020;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int WRITE_TIME_NS = 5_000_000;
    localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 20;

    // ****************************************
    // State types
    // ****************************************
    localparam int SYNC_W = 5;
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 5'h1f;

    typedef struct packed {
        logic [SYNC_W-1:0] stage1;
        logic [SYNC_W-1:0] stage2;
    } seh_sync_s;

    typedef struct packed {
        logic sclk_d;
        logic cs_d;
        logic paused;
        logic [CNT_W-1:0] cnt;
        logic [15:0] sh;
        logic [7:0] op;
        logic drop;
        logic [ADDR_W-1:0] addr;
        logic [7:0] sr_new;
        logic pend_sr;
        logic write_enable_latch;
        logic busy_flag;
        logic [1:0] protect_level;
        logic status_lock_bit;
        logic [TMR_W-1:0] tmr;
        logic rd_on;
        logic dout;
        logic doe;
    } seh_state_s;

endpackage : seh_pkg

// ==== testbench/seh_master.sv ====
// SPI bus master model that drives the serial EEPROM pins
`timescale 1ns/1ps
module seh_master (
    input wire logic clk,
    input wire logic spi_do,
    input wire logic spi_do_oe,
    output logic spi_cs_n,
    output logic spi_clk,
    output logic spi_di,
    output logic hold_n
);
    logic last_do;
    logic miso;

    initial begin
        spi_cs_n = 1'h1;
        spi_clk = 1'h0;
        spi_di = 1'h0;
        hold_n = 1'h1;
        last_do = 1'h0;
    end

    // Released line shows the inverse of the last driven bit
    always @(posedge clk) begin
        if (spi_do_oe) begin
            last_do <= spi_do;
        end
    end
    assign miso = spi_do_oe ? spi_do : ~last_do;

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk

    // One frame, MSB first, half period of four clocks
    task automatic xfer(input logic mode3, input int nbits, input logic [31:0] tx,
                        input int hold_at, output logic [31:0] rx, output logic oe_held);
        rx = 32'h0;
        oe_held = 1'h1;
        wait_clk(1);
        spi_clk <= mode3;
        wait_clk(4);
        spi_cs_n <= 1'h0;
        wait_clk(4);
        for (int i = nbits - 1; i >= 0; i--) begin
            spi_clk <= 1'h0;
            spi_di <= tx[i];
            wait_clk(4);
            if (i == hold_at) begin
                hold_n <= 1'h0;
                wait_clk(6);
                @(negedge clk);
                oe_held = spi_do_oe;
                wait_clk(1);
                spi_clk <= 1'h1;
                spi_di <= ~tx[i];
                wait_clk(4);
                spi_clk <= 1'h0;
                spi_di <= tx[i];
                wait_clk(4);
                hold_n <= 1'h1;
                wait_clk(6);
            end
            spi_clk <= 1'h1;
            wait_clk(2);
            @(negedge clk);
            rx = {rx[30:0], miso};
            wait_clk(2);
        end
        spi_clk <= mode3;
        wait_clk(4);
        spi_cs_n <= 1'h1;
        wait_clk(6);
        @(negedge clk);
    endtask : xfer
endmodule : seh_master

// ==== testbench/test_spi_eeprom_hold_write_protect.sv ====
// Self-checking bench for the serial EEPROM front end
`timescale 1ns/1ps
module test_spi_eeprom_hold_write_protect;
    localparam int WCYC = 2000;
    localparam int NR = 31;
    localparam int LIMIT = 80000;

    typedef struct {
        logic mode3;
        int nbits;
        logic [31:0] tx;
        logic guard_n;
        logic poll;
        logic [7:0] exp_st;
        logic [7:0] mask;
    } seh_row_s;

    logic clk;
    logic resetn;
    logic cs_n;
    logic sclk;
    logic di;
    logic hold_n;
    logic guard_n;
    logic sdo;
    logic do_oe;
    int n_fail = 0;
    int checks = 0;
    int cycle_cnt = 0;
    seh_row_s rows [0:NR-1];

    seh_front #(.WRITE_CYCLES(WCYC)) i_dut (
        .clk(clk), .resetn(resetn), .spi_cs_n(cs_n), .spi_clk(sclk), .spi_di(di),
        .hold_n(hold_n), .write_guard_n(guard_n), .spi_do(sdo), .spi_do_oe(do_oe)
    );

    seh_master i_master (
        .clk(clk), .spi_do(sdo), .spi_do_oe(do_oe), .spi_cs_n(cs_n), .spi_clk(sclk),
        .spi_di(di), .hold_n(hold_n)
    );

    initial begin
        clk = 1'h0;
        resetn = 1'h0;
        guard_n = 1'h1;
    end

    always #5 clk = ~clk;

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic end_of_test();
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check_val(input string what, input logic [7:0] exp_v, input logic [7:0] got);
        checks++;
        if (got !== exp_v) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp_v, got);
        end
    endtask : check_val

    task automatic read_status(input logic mode3, input int hold_at, output logic [7:0] st,
                               output logic held);
        logic [31:0] rx;
        i_master.xfer(mode3, 16, {16'h0, seh_pkg::STATUS_READ_CMD, 8'h00}, hold_at, rx, held);
        st = rx[7:0];
        check_val("output enable deselected", 8'h00, {7'h0, do_oe});
    endtask : read_status

    always @(posedge clk) begin
        cycle_cnt++;
        if (cycle_cnt == LIMIT) begin
            n_fail++;
            end_of_test();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [7:0] st;
        logic held;
        logic [31:0] rx;
        rows = '{
            '{1'h0, 8, 32'h04, 1'h1, 1'h0, 8'h00, 8'hff},
            '{1'h0, 5, 32'h00, 1'h1, 1'h0, 8'h00, 8'hff},
            '{1'h0, 8, 32'h06, 1'h1, 1'h0, 8'h02, 8'hff},
            '{1'h1, 8, 32'h04, 1'h1, 1'h0, 8'h00, 8'hff},
            '{1'h0, 16, 32'h0180, 1'h1, 1'h0, 8'h00, 8'hff},
            '{1'h0, 8, 32'h06, 1'h1, 1'h0, 8'h02, 8'hff},
            '{1'h0, 15, 32'h00c0, 1'h1, 1'h0, 8'h02, 8'hff},
            '{1'h0, 16, 32'h01ff, 1'h1, 1'h0, 8'h01, 8'h01},
            '{1'h1, 8, 32'h06, 1'h1, 1'h1, 8'h8c, 8'hff},
            '{1'h0, 8, 32'h06, 1'h1, 1'h0, 8'h8e, 8'hff},
            '{1'h0, 16, 32'h0100, 1'h0, 1'h1, 8'h8c, 8'hfd},
            '{1'h0, 8, 32'h06, 1'h1, 1'h0, 8'h8e, 8'hff},
            '{1'h0, 16, 32'h0104, 1'h1, 1'h1, 8'h04, 8'hff},
            '{1'h0, 8, 32'h06, 1'h1, 1'h0, 8'h06, 8'hff},
            '{1'h0, 32, 32'h020300a5, 1'h1, 1'h1, 8'h04, 8'hfd},
            '{1'h0, 8, 32'h06, 1'h1, 1'h0, 8'h06, 8'hff},
            '{1'h1, 32, 32'h0202ff5a, 1'h1, 1'h1, 8'h04, 8'hff},
            '{1'h0, 8, 32'h06, 1'h1, 1'h0, 8'h06, 8'hff},
            '{1'h0, 31, 32'h01017fad, 1'h1, 1'h1, 8'h06, 8'hff},
            '{1'h0, 32, 32'h82000000, 1'h1, 1'h1, 8'h04, 8'hff},
            '{1'h0, 8, 32'h06, 1'h1, 1'h0, 8'h06, 8'hff},
            '{1'h0, 16, 32'h010c, 1'h1, 1'h1, 8'h0c, 8'hff},
            '{1'h0, 8, 32'h06, 1'h1, 1'h0, 8'h0e, 8'hff},
            '{1'h0, 32, 32'h02000011, 1'h1, 1'h1, 8'h0c, 8'hfd},
            '{1'h0, 8, 32'h04, 1'h1, 1'h0, 8'h0c, 8'hff},
            '{1'h0, 8, 32'h06, 1'h1, 1'h0, 8'h0e, 8'hff},
            '{1'h0, 16, 32'h0108, 1'h1, 1'h1, 8'h08, 8'hff},
            '{1'h0, 8, 32'h06, 1'h1, 1'h0, 8'h0a, 8'hff},
            '{1'h0, 32, 32'h02020000, 1'h1, 1'h1, 8'h08, 8'hfd},
            '{1'h0, 8, 32'h06, 1'h1, 1'h0, 8'h0a, 8'hff},
            '{1'h0, 32, 32'h0201ff00, 1'h1, 1'h1, 8'h08, 8'hff}
        };
        repeat (10) @(posedge clk);
        resetn <= 1'h1;
        repeat (5) @(posedge clk);
        for (int i = 0; i < NR; i++) begin
            @(posedge clk);
            guard_n <= rows[i].guard_n;
            i_master.xfer(rows[i].mode3, rows[i].nbits, rows[i].tx, -1, rx, held);
            if (rows[i].poll) begin
                for (int k = 0; k < 40; k++) begin
                    read_status(rows[i].mode3, -1, st, held);
                    if (st[seh_pkg::BUSY_POS] === 1'h0) begin
                        break;
                    end
                end
            end
            read_status(rows[i].mode3, -1, st, held);
            check_val("status", rows[i].exp_st & rows[i].mask, st & rows[i].mask);
        end
        // Pause in mid-read with the clock low, spurious clock while paused
        read_status(1'h0, 5, st, held);
        check_val("output enable paused", 8'h00, {7'h0, held});
        check_val("status across pause", 8'h08, st);
        // Second reset in mid-run returns to the power-up state
        @(posedge clk);
        resetn <= 1'h0;
        repeat (3) @(posedge clk);
        resetn <= 1'h1;
        repeat (5) @(posedge clk);
        read_status(1'h1, -1, st, held);
        check_val("status after reset", 8'h00, st);
        end_of_test();
    end
endmodule : test_spi_eeprom_hold_write_protect
